// ---- rtl/spi_uart.sv ----
// SPI-attached asynchronous serial transceiver: SPI slave register port,
// transmitter, receiver with four-entry buffer, and pulsed event output.
// Assumes SPI mode 0 with SCK at most core_clk/16, select driven or pulled high.
`timescale 1ns/10ps
`default_nettype none
module spi_uart
  import uart_pkg::*;
(
  // Clock and reset, clock supplied by the host
  input  wire logic core_clk,
  input  wire logic rst,
  // Host SPI link
  input  wire logic host_sck,
  input  wire logic host_select_n,
  input  wire logic host_sdi,
  output var  logic host_sdo_r,
  output var  logic host_sdo_oe_n_r,
  // Event to host
  output var  logic host_event_n_r,
  // Serial line
  input  wire logic rx_pin,
  output var  logic tx_pin_r,
  output var  logic tx_oe_n_r
);

  // ==========================================================================
  // Pin synchronisers
  logic sck_q;
  logic sel_n_q;
  logic sdi_q;
  logic rx_q;

  pin_sync3 #(.RST_VAL(1'b0)) u_sck (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (host_sck),
    .level_r  (sck_q)
  );
  // Resets deselected, matching the pulled-up select line
  pin_sync3 #(.RST_VAL(1'b1)) u_sel (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (host_select_n),
    .level_r  (sel_n_q)
  );
  pin_sync3 #(.RST_VAL(1'b0)) u_sdi (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (host_sdi),
    .level_r  (sdi_q)
  );
  pin_sync3 #(.RST_VAL(1'b1)) u_rx (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (rx_pin),
    .level_r  (rx_q)
  );

  // ==========================================================================
  // Registers and shared signals
  cfg_t       cfg_r;
  logic [7:0] baud_r;
  logic [4:0] mask_r;
  logic       tx_bit8_r;
  logic [4:0] sticky_r;
  logic       wr_en_r;
  logic [3:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic       pop_r;
  logic       tx_on;
  logic       rx_on;
  logic       baud_tick;

  assign tx_on = cfg_r.mod_en & cfg_r.tx_en;
  assign rx_on = cfg_r.mod_en & cfg_r.rx_en;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_r     <= cfg_t'(CTRL_RST);
      baud_r    <= BAUD_RST;
      mask_r    <= MASK_RST;
      tx_bit8_r <= 1'b0;
    end else if (wr_en_r) begin
      unique case (wr_addr_r)
        A_CTRL:   cfg_r     <= cfg_t'(wr_data_r);
        A_BAUD:   baud_r    <= wr_data_r;
        A_MASK:   mask_r    <= wr_data_r[4:0];
        A_TXBIT8: tx_bit8_r <= wr_data_r[0];
        default:  ;
      endcase
    end
  end

  // ==========================================================================
  // Baud generator: tick every baud_r+1 clocks, 16 ticks per bit
  logic [7:0] presc_r;

  always_ff @(posedge core_clk) begin
    if (rst || !cfg_r.mod_en) begin
      presc_r <= 8'h00;
    end else if (presc_r == baud_r) begin
      presc_r <= 8'h00;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end
  assign baud_tick = cfg_r.mod_en && (presc_r == baud_r);

  // ==========================================================================
  // Transmitter with one-character holding buffer, apart from the receiver
  ser_state_t tx_st_r;
  logic [3:0] tx_os_r;
  logic [3:0] tx_bit_r;
  logic [8:0] tx_sh_r;
  logic [8:0] tx_buf_r;
  logic       tx_buf_full_r;
  logic       tx_par_r;
  logic       tx_stop2_r;
  logic       tx_end;
  logic       tx_wr;

  assign tx_end = baud_tick && (tx_os_r == OS_LAST) && (tx_st_r != S_IDLE);
  assign tx_wr  = wr_en_r && (wr_addr_r == A_TXDATA);

  always_ff @(posedge core_clk) begin
    if (rst || !tx_on) begin
      tx_st_r       <= S_IDLE;
      tx_os_r       <= 4'h0;
      tx_bit_r      <= 4'h0;
      tx_sh_r       <= 9'h000;
      tx_buf_r      <= 9'h000;
      tx_buf_full_r <= 1'b0;
      tx_par_r      <= 1'b0;
      tx_stop2_r    <= 1'b0;
      tx_pin_r      <= 1'b1;
    end else begin
      if (tx_st_r != S_IDLE && baud_tick) begin
        tx_os_r <= tx_os_r + 4'h1;
      end
      // A write to a full buffer is dropped
      if (tx_wr && !tx_buf_full_r) begin
        tx_buf_r      <= {tx_bit8_r, wr_data_r};
        tx_buf_full_r <= 1'b1;
      end
      unique case (tx_st_r)
        S_IDLE: begin
          tx_pin_r <= 1'b1;
          // Start only on a tick, else the start bit is cut short by the prescaler phase
          if (tx_buf_full_r && baud_tick) begin
            tx_sh_r       <= tx_buf_r;
            tx_par_r      <= parity_of(tx_buf_r, cfg_r);
            tx_buf_full_r <= 1'b0;
            tx_os_r       <= 4'h0;
            tx_st_r       <= S_START;
            tx_pin_r      <= 1'b0;
          end
        end
        S_START: if (tx_end) begin
          tx_bit_r <= 4'h0;
          tx_pin_r <= tx_sh_r[0];
          tx_st_r  <= S_DATA;
        end
        S_DATA: if (tx_end) begin
          if (tx_bit_r == (cfg_r.nine_bit ? 4'h8 : 4'h7)) begin
            tx_stop2_r <= 1'b0;
            if (cfg_r.par_en) begin
              tx_pin_r <= tx_par_r;
              tx_st_r  <= S_PAR;
            end else begin
              tx_pin_r <= 1'b1;
              tx_st_r  <= S_STOP;
            end
          end else begin
            tx_bit_r <= tx_bit_r + 4'h1;
            tx_sh_r  <= {1'b0, tx_sh_r[8:1]};
            tx_pin_r <= tx_sh_r[1];
          end
        end
        S_PAR: if (tx_end) begin
          tx_pin_r <= 1'b1;
          tx_st_r  <= S_STOP;
        end
        S_STOP: if (tx_end) begin
          if (cfg_r.two_stop && !tx_stop2_r) begin
            tx_stop2_r <= 1'b1;
          end else begin
            tx_st_r <= S_IDLE;
          end
        end
        default: tx_st_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_oe_n_r <= 1'b1;
    end else begin
      tx_oe_n_r <= !tx_on;
    end
  end

  // ==========================================================================
  // Receiver: three samples mid-bit, majority vote, disagreement is noise
  ser_state_t rx_st_r;
  logic [3:0] rx_os_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic [2:0] rx_smp_r;
  logic       rx_perr_r;
  logic       rx_noise_r;
  logic       rx_push_r;
  logic [8:0] rx_word_r;
  logic [4:0] rx_ev_r;
  logic       rx_end;
  logic       maj;
  logic       noisy;
  logic       last_bit;
  logic       fifo_full;

  assign rx_end   = baud_tick && (rx_os_r == OS_LAST) && (rx_st_r != S_IDLE);
  assign maj      = (rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[1] & rx_smp_r[2])
                  | (rx_smp_r[0] & rx_smp_r[2]);
  assign noisy    = !(&rx_smp_r) && (|rx_smp_r);
  assign last_bit = cfg_r.nine_bit ? rx_sh_r[8] : rx_sh_r[7];

  always_ff @(posedge core_clk) begin
    if (rst || !rx_on) begin
      rx_st_r    <= S_IDLE;
      rx_os_r    <= 4'h0;
      rx_bit_r   <= 4'h0;
      rx_sh_r    <= 9'h000;
      rx_smp_r   <= 3'h0;
      rx_perr_r  <= 1'b0;
      rx_noise_r <= 1'b0;
      rx_push_r  <= 1'b0;
      rx_word_r  <= 9'h000;
      rx_ev_r    <= 5'h00;
    end else begin
      rx_push_r <= 1'b0;
      rx_ev_r   <= 5'h00;
      if (rx_st_r != S_IDLE && baud_tick) begin
        rx_os_r <= rx_os_r + 4'h1;
        if (rx_os_r >= OS_MID0 && rx_os_r <= OS_MID2) begin
          rx_smp_r <= {rx_smp_r[1:0], rx_q};
        end
      end
      unique case (rx_st_r)
        S_IDLE: if (baud_tick && !rx_q) begin
          rx_os_r    <= 4'h1;
          rx_sh_r    <= 9'h000;
          rx_noise_r <= 1'b0;
          rx_perr_r  <= 1'b0;
          rx_st_r    <= S_START;
        end
        S_START: if (rx_end) begin
          rx_bit_r   <= 4'h0;
          rx_noise_r <= noisy;
          rx_st_r    <= maj ? S_IDLE : S_DATA;  // High start is a glitch
        end
        S_DATA: if (rx_end) begin
          rx_sh_r[rx_bit_r] <= maj;
          rx_noise_r        <= rx_noise_r | noisy;
          rx_bit_r          <= rx_bit_r + 4'h1;
          if (rx_bit_r == (cfg_r.nine_bit ? 4'h8 : 4'h7)) begin
            rx_st_r <= cfg_r.par_en ? S_PAR : S_STOP;
          end
        end
        S_PAR: if (rx_end) begin
          rx_perr_r  <= maj != parity_of(rx_sh_r, cfg_r);
          rx_noise_r <= rx_noise_r | noisy;
          rx_st_r    <= S_STOP;
        end
        S_STOP: if (rx_end) begin
          rx_st_r             <= S_IDLE;
          rx_word_r           <= rx_sh_r;
          rx_push_r           <= !fifo_full;
          rx_ev_r[ST_PERR]    <= rx_perr_r;
          rx_ev_r[ST_FERR]    <= !maj;
          rx_ev_r[ST_NOISE]   <= rx_noise_r | noisy;
          rx_ev_r[ST_OVR]     <= fifo_full;
          rx_ev_r[ST_ADDR]    <= cfg_r.addr_mode && last_bit;
        end
        default: rx_st_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Receive buffer, four entries
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic [1:0] wr_ptr_r;
  logic [1:0] rd_ptr_r;
  logic [2:0] count_r;
  logic       fifo_pop;

  assign fifo_full = (count_r == 3'(FIFO_DEPTH));
  assign fifo_pop  = pop_r && (count_r != 3'h0);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      count_r  <= 3'h0;
    end else begin
      if (rx_push_r) begin
        fifo_mem[wr_ptr_r] <= rx_word_r;
        wr_ptr_r           <= wr_ptr_r + 2'h1;
      end
      if (fifo_pop) begin
        rd_ptr_r <= rd_ptr_r + 2'h1;
      end
      count_r <= count_r + 3'(rx_push_r) - 3'(fifo_pop);
    end
  end

  // ==========================================================================
  // Sticky status: a new event wins over a clear in the same cycle
  logic [4:0] st_clr;

  assign st_clr = (wr_en_r && wr_addr_r == A_STAT) ? wr_data_r[4:0] : 5'h00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sticky_r <= 5'h00;
    end else begin
      sticky_r <= (sticky_r & ~st_clr) | rx_ev_r;
    end
  end

  // ==========================================================================
  // Event output: low pulse on a new enabled condition
  logic [4:0] src;
  logic [4:0] src_prev_r;
  logic [3:0] int_cnt_r;
  logic       tx_empty;
  logic       tx_idle;

  assign tx_empty          = tx_on && !tx_buf_full_r;
  assign tx_idle           = tx_empty && (tx_st_r == S_IDLE);
  assign src[IS_TXE]       = tx_empty;
  assign src[IS_TXI]       = tx_idle;
  assign src[IS_RXF]       = (count_r != 3'h0) && !cfg_r.addr_mode;
  assign src[IS_OVR]       = sticky_r[ST_OVR];
  assign src[IS_ADDR]      = sticky_r[ST_ADDR];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_prev_r     <= 5'h00;
      int_cnt_r      <= 4'h0;
      host_event_n_r <= 1'b1;
    end else begin
      src_prev_r <= src;
      if (|(src & ~src_prev_r & mask_r)) begin
        int_cnt_r <= 4'(INT_PULSE_CYC);
      end else if (int_cnt_r != 4'h0) begin
        int_cnt_r <= int_cnt_r - 4'h1;
      end
      host_event_n_r <= (int_cnt_r == 4'h0);
    end
  end

  // ==========================================================================
  // SPI slave, mode 0, MSB first: command byte then data byte
  logic       sck_d_r;
  logic [3:0] sbit_r;
  logic [6:0] sin_r;
  logic [7:0] cmd_r;
  logic [7:0] sout_r;
  logic [7:0] rd_val;
  logic [7:0] status;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] sbyte;

  assign sck_rise = sck_q && !sck_d_r;
  assign sck_fall = !sck_q && sck_d_r;
  assign sbyte    = {sin_r, sdi_q};
  assign status   = {count_r != 3'h0, tx_idle, tx_empty, sticky_r};

  always_comb begin
    unique case (sbyte[3:0])
      A_CTRL:   rd_val = cfg_r;
      A_TXBIT8: rd_val = {7'h00, tx_bit8_r};
      A_BAUD:   rd_val = baud_r;
      A_STAT:   rd_val = status;
      A_MASK:   rd_val = {3'h0, mask_r};
      A_RXDATA: rd_val = fifo_mem[rd_ptr_r][7:0];
      A_RXBIT8: rd_val = {7'h00, fifo_mem[rd_ptr_r][8]};
      default:  rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_d_r         <= 1'b0;
      sbit_r          <= 4'h0;
      sin_r           <= 7'h00;
      cmd_r           <= 8'h00;
      sout_r          <= 8'h00;
      wr_en_r         <= 1'b0;
      wr_addr_r       <= 4'h0;
      wr_data_r       <= 8'h00;
      pop_r           <= 1'b0;
      host_sdo_r      <= 1'b0;
      host_sdo_oe_n_r <= 1'b1;
    end else begin
      sck_d_r         <= sck_q;
      wr_en_r         <= 1'b0;
      pop_r           <= 1'b0;
      host_sdo_oe_n_r <= sel_n_q;
      if (sel_n_q) begin
        sbit_r     <= 4'h0;
        host_sdo_r <= 1'b0;
      end else begin
        if (sck_rise) begin
          sin_r  <= sbyte[6:0];
          sbit_r <= sbit_r + 4'h1;
          if (sbit_r == 4'h7) begin
            cmd_r <= sbyte;
            if (!sbyte[CMD_WR_BIT]) begin
              sout_r <= rd_val;
              pop_r  <= (sbyte[3:0] == A_RXDATA);  // Read takes the entry
            end else begin
              sout_r <= 8'h00;
            end
          end
          if (sbit_r == 4'hF) begin
            wr_en_r   <= cmd_r[CMD_WR_BIT];
            wr_addr_r <= cmd_r[3:0];
            wr_data_r <= sbyte;
          end
        end
        if (sck_fall && sbit_r[3]) begin
          host_sdo_r <= sout_r[7];
          sout_r     <= {sout_r[6:0], 1'b0};
        end else if (sck_fall) begin
          host_sdo_r <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- include/uart_pkg.sv ----
// Constants, types and helpers shared by the SPI-attached serial transceiver.
// Assumes a single 10 MHz core clock and a host acting as SPI master.
//
// Overview of operation
// - Transmitter and receiver run at the same time, independently of each other.
// - Characters are 8 or 9 data bits, chosen by configuration.
// - Even, odd or no parity; generated on transmit, checked on receive.
// - One or two stop bits are appended to each transmitted character.
// - Bit timing comes from an 8-bit programmable prescaler on the module clock.
// - Receiver flags parity, framing, noise and overrun errors.
// - Address mode interrupts only on characters whose last data bit is 1.
// - Transmitter and receiver each have their own enable.
// - Received characters wait in a four-entry first-in first-out buffer.
// - Interrupt sources: transmitter empty, idle, receiver full, overrun, address.
// - Transmit pin driven only with module and transmit enables set.
// - Receive pin used only with module and receive enables set.
// - A newly raised enabled interrupt condition gives a low pulse on the event output.
// - Host is SPI master; the module is SPI slave answering on data out.
// - Select idles high (pulled up), so the slave stays deselected when undriven.
// - Host supplies the module clock, assumed to be 10 MHz (CLK_MHZ).
`default_nettype none
package uart_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ          = 10;
  localparam int INT_PULSE_NS     = 1000;
  localparam int INT_PULSE_CYC    = (INT_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] OS_LAST  = 4'hF;
  localparam logic [3:0] OS_MID0  = 4'h7;
  localparam logic [3:0] OS_MID2  = 4'h9;

  // ==========================================================================
  // SPI register map (4-bit address, bit 7 of command = write)
  localparam int CMD_WR_BIT       = 7;
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_TXBIT8 = 4'h1;
  localparam logic [3:0] A_BAUD   = 4'h2;
  localparam logic [3:0] A_STAT   = 4'h3;
  localparam logic [3:0] A_MASK   = 4'h4;
  localparam logic [3:0] A_TXDATA = 4'h5;
  localparam logic [3:0] A_RXDATA = 4'h6;
  localparam logic [3:0] A_RXBIT8 = 4'h7;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [4:0] MASK_RST = 5'h00;

  // Status bit positions; bits 4:0 are sticky and clear on writing 1
  localparam int ST_PERR  = 0;
  localparam int ST_FERR  = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_OVR   = 3;
  localparam int ST_ADDR  = 4;
  localparam int ST_TXE   = 5;
  localparam int ST_TXI   = 6;
  localparam int ST_RXA   = 7;

  // Interrupt source / mask positions
  localparam int IS_TXE  = 0;
  localparam int IS_TXI  = 1;
  localparam int IS_RXF  = 2;
  localparam int IS_OVR  = 3;
  localparam int IS_ADDR = 4;

  localparam int FIFO_DEPTH = 4;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic addr_mode;
    logic two_stop;
    logic par_odd;
    logic par_en;
    logic nine_bit;
    logic rx_en;
    logic tx_en;
    logic mod_en;
  } cfg_t;

  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ser_state_t;

  // Parity over the active data bits
  function automatic logic parity_of(input logic [8:0] d, input cfg_t c);
    parity_of = (^d[7:0]) ^ (c.nine_bit & d[8]) ^ c.par_odd;
  endfunction

endpackage
`default_nettype wire

// ---- rtl/pin_sync3.sv ----
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to core_clk; output moves only when stages 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Pin and result
  input  wire logic pin_in,
  output var  logic level_r
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      level_r <= RST_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

endmodule
`default_nettype wire

// ---- testbench/spi_uart_asserts.sv ----
// Port checker for the SPI-attached serial transceiver, bound to spi_uart.
// Assumes the host holds select low at least 16 cycles past the last SCK fall.
`timescale 1ns/10ps
`default_nettype none
module spi_uart_asserts
  import uart_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host link
  input wire logic host_sck,
  input wire logic host_select_n,
  input wire logic host_sdi,
  input wire logic host_sdo_r,
  input wire logic host_sdo_oe_n_r,
  input wire logic host_event_n_r,
  // Serial line
  input wire logic rx_pin,
  input wire logic tx_pin_r,
  input wire logic tx_oe_n_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Run lengths, saturating so long idles never wrap
  logic [7:0] evt_lo_r;
  logic [9:0] tx_lo_r;
  logic [9:0] tx_hi_r;
  always_ff @(posedge core_clk) begin
    if (rst || host_event_n_r) evt_lo_r <= 8'h00;
    else if (evt_lo_r != 8'hFF) evt_lo_r <= evt_lo_r + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    if (rst || tx_pin_r || tx_oe_n_r) tx_lo_r <= 10'h000;
    else if (tx_lo_r != 10'h3FF) tx_lo_r <= tx_lo_r + 10'h001;
  end
  always_ff @(posedge core_clk) begin
    if (rst || !tx_pin_r) tx_hi_r <= 10'h000;
    else if (tx_hi_r != 10'h3FF) tx_hi_r <= tx_hi_r + 10'h001;
  end
  // ==========================================================================
  // Properties
  rst_idle_a: assert property (disable iff (1'b0) rst |=> tx_pin_r && tx_oe_n_r
    && host_event_n_r && host_sdo_oe_n_r && !host_sdo_r) else $error("outputs not idle in reset");
  evt_len_a: assert property ($rose(host_event_n_r) |-> int'(evt_lo_r) >= INT_PULSE_CYC)
    else $error("event pulse too short");
  tx_low_a: assert property ($rose(tx_pin_r) && !tx_oe_n_r |-> tx_lo_r != 10'h000
    && tx_lo_r[3:0] == 4'h0) else $error("low run not a whole bit time");
  tx_high_a: assert property ($fell(tx_pin_r) && !tx_oe_n_r |-> tx_hi_r >= 10'h010)
    else $error("high run shorter than a bit");
  tx_hiz_a: assert property (tx_oe_n_r && $past(tx_oe_n_r) |-> tx_pin_r)
    else $error("undriven transmit not idle high");
  sdo_desel_a: assert property (host_select_n [*8] |-> host_sdo_oe_n_r)
    else $error("data out driven while deselected");
  sdo_sel_a: assert property (!host_select_n [*8] |-> !host_sdo_oe_n_r)
    else $error("data out not driven while selected");
  cfg_sel_a: assert property ($changed(tx_oe_n_r) |-> !$past(host_select_n, 8))
    else $error("enable changed outside a host frame");
  evt_c: cover property ($fell(host_event_n_r));
  tx_c: cover property ($fell(tx_pin_r) && !tx_oe_n_r);
  sdo_c: cover property ($fell(host_sdo_oe_n_r));
endmodule
bind spi_uart spi_uart_asserts i_spi_uart_asserts (
  .core_clk, .rst, .host_sck, .host_select_n, .host_sdi, .host_sdo_r,
  .host_sdo_oe_n_r, .host_event_n_r, .rx_pin, .tx_pin_r, .tx_oe_n_r
);
`default_nettype wire

// ---- testbench/host_spi_master.sv ----
// Host model: SPI master, mode 0, SCK half period 8 core cycles.
// Assumes the caller enters xfer just after a core_clk edge.
`timescale 1ns/10ps
`default_nettype none
module host_spi_master (
  // Clock
  input  wire logic core_clk,
  // SPI pins
  output var  logic sck,
  output var  logic sel_n,
  output var  logic sdi,
  input  wire logic sdo
);
  logic idle_r = 1'b1;
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
  end
  // Data in is meaningless between frames, so it keeps moving
  always @(posedge core_clk) if (idle_r) sdi <= ~sdi;
  // ==========================================================================
  // One frame: command byte, then data byte, MSB first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] w;
    int          i;
    w = {cmd, wd};
    rd = 8'h00;
    @(posedge core_clk);
    sel_n <= 1'b0;
    idle_r <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (i = 0; i < 16; i++) begin
      sdi <= w[15 - i];
      repeat (8) @(posedge core_clk);
      sck <= 1'b1;
      if (i >= 8) rd = {rd[6:0], sdo};
      repeat (8) @(posedge core_clk);
      sck <= 1'b0;
    end
    repeat (16) @(posedge core_clk);
    sel_n <= 1'b1;
    idle_r <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench: host model on SPI, transmit looped to receive or driven raw.
// Assumes a 10 MHz core clock and the block's SPI register map.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import uart_pkg::*;
;
  logic       core_clk;
  logic       rst;
  logic       host_sck;
  logic       host_select_n;
  logic       host_sdi;
  logic       host_sdo_r;
  logic       host_sdo_oe_n_r;
  logic       host_event_n_r;
  logic       rx_pin;
  logic       rx_drv;
  logic       loop_r;
  logic       tx_pin_r;
  logic       tx_oe_n_r;
  logic       evt_q = 1'b1;
  int         pulses = 0;
  int         errors = 0;
  int         samples_checked = 0;
  wire logic  sdo_w = host_sdo_oe_n_r ? ~host_sdo_r : host_sdo_r;
  assign rx_pin = loop_r ? tx_pin_r : rx_drv;
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  spi_uart i_spi_uart (.core_clk(core_clk), .rst(rst), .host_sck(host_sck),
    .host_select_n(host_select_n), .host_sdi(host_sdi), .host_sdo_r(host_sdo_r),
    .host_sdo_oe_n_r(host_sdo_oe_n_r), .host_event_n_r(host_event_n_r),
    .rx_pin(rx_pin), .tx_pin_r(tx_pin_r), .tx_oe_n_r(tx_oe_n_r));
  host_spi_master i_host_spi_master (.core_clk(core_clk), .sck(host_sck),
    .sel_n(host_select_n), .sdi(host_sdi), .sdo(sdo_w));
  always @(posedge core_clk) begin
    evt_q <= host_event_n_r;
    if (!rst && evt_q && !host_event_n_r) pulses <= pulses + 1;
  end
  // ==========================================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host_spi_master.xfer({4'h8, a}, d, q);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    i_host_spi_master.xfer({4'h0, a}, 8'h00, q);
  endtask
  function automatic int nbits(input cfg_t c);
    return 10 + c.nine_bit + c.par_en + c.two_stop;
  endfunction
  function automatic logic [12:0] frame_of(input logic [8:0] d, input cfg_t c);
    logic [12:0] f;
    int          p;
    int          k;
    f = 13'h1FFE;
    p = 1;
    for (k = 0; k < 9; k++) if (k < 8 || c.nine_bit) begin
      f[p] = d[k];
      p++;
    end
    if (c.par_en) f[p] = ^(d & {c.nine_bit, 8'hFF}) ^ c.par_odd;
    return f;
  endfunction
  // Waits for the start bit, then samples each bit at its centre
  task automatic tx_check(input logic [8:0] d, input cfg_t c, input int bt);
    logic [12:0] f;
    int          k;
    f = frame_of(d, c);
    k = 0;
    while (tx_pin_r !== 1'b0 && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    check(16'(k < 4000), 16'h0001);
    repeat (bt / 2) @(posedge core_clk);
    for (k = 0; k < nbits(c); k++) begin
      check(16'(tx_pin_r), 16'(f[k]));
      repeat (bt) @(posedge core_clk);
    end
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    errors++;
    print_verdict();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0]  q;
    logic [7:0]  q2;
    logic [7:0]  p;
    logic [8:0]  d;
    logic [8:0]  sent [5];
    logic [12:0] f;
    logic [3:0]  regs [4];
    cfg_t        c;
    int          r;
    int          j;
    int          bitpos;
    rst = 1'b1;
    loop_r = 1'b1;
    rx_drv = 1'b1;
    regs = '{A_CTRL, A_BAUD, A_MASK, 4'hC};
    void'($urandom(32'hdf600d61));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check({12'h000, tx_pin_r, tx_oe_n_r, host_event_n_r, host_sdo_oe_n_r}, 16'h000F);
    wr(4'hC, 8'hFF);
    for (j = 0; j < 4; j++) begin
      rd(regs[j], q);
      check(16'(q), 16'h0000);
    end
    for (r = 0; r < 4; r++) begin
      c = cfg_t'(8'($urandom));
      if (r < 2) c = cfg_t'(r == 0 ? 8'h07 : 8'h7F);
      c.addr_mode = 1'b0;
      c[2:0] = 3'h7;
      p = 8'(r == 1 ? 2 : $urandom_range(0, 1));
      wr(A_BAUD, p);
      wr(A_MASK, 8'h04);
      wr(A_CTRL, c);
      rd(A_BAUD, q);
      check({q, 7'h00, tx_oe_n_r}, {p, 8'h00});
      for (j = 0; j < 5; j++) begin
        d = (j == 0) ? 9'h1FF : (j == 1) ? 9'h000 : 9'($urandom);
        d = d & {c.nine_bit, 8'hFF};
        sent[j] = d;
        wr(A_TXBIT8, {7'h00, d[8]});
        fork
          wr(A_TXDATA, d[7:0]);
          tx_check(d, c, 16 * (p + 1));
        join
      end
      rd(A_STAT, q);
      check(16'(q), 16'h00E8);
      for (j = 0; j < 4; j++) begin
        rd(A_RXBIT8, q);
        rd(A_RXDATA, q2);
        check({7'h00, q[0] & c.nine_bit, q2}, 16'(sent[j]));
      end
      wr(A_STAT, 8'h1F);
      rd(A_STAT, q);
      check(16'(q), 16'h0060);
      check(16'(pulses), 16'(r + 1));
      wr(A_CTRL, c & (r[0] ? 8'hFE : 8'hFD));
      check(16'(tx_oe_n_r), 16'h0001);
    end
    // Raw characters with transmit off: address, bad parity, bad stop, noise
    loop_r <= 1'b0;
    wr(A_BAUD, 8'h01);
    for (r = 0; r < 4; r++) begin
      c = cfg_t'(r == 0 ? 8'h8D : r == 1 ? 8'h15 : 8'h05);
      f = frame_of(9'h1A5 & {c.nine_bit, 8'hFF}, c);
      if (r == 1 || r == 2) f[9] = (r == 1) ? ~f[9] : 1'b0;
      bitpos = (r == 0) ? ST_ADDR : (r == 1) ? ST_PERR : (r == 2) ? ST_FERR : ST_NOISE;
      wr(A_CTRL, c);
      for (j = 0; j < nbits(c); j++) begin
        rx_drv <= f[j];
        repeat (16) @(posedge core_clk);
        // Two-cycle glitch mid-bit hits one of the three votes only
        if (r == 3 && j == 1) rx_drv <= ~f[j];
        repeat (2) @(posedge core_clk);
        rx_drv <= f[j];
        repeat (14) @(posedge core_clk);
      end
      rx_drv <= 1'b1;
      repeat (64) @(posedge core_clk);
      rd(A_STAT, q);
      check({14'h0000, tx_oe_n_r, q[bitpos]}, 16'h0003);
      wr(A_STAT, 8'h1F);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
